// File: hdl/timer_pair_pkg.sv
// Shared constants and types for the paired 8-bit interval timer.
package timer_pair_pkg;

    // Register indices; the APB byte address is four times the index.
    localparam logic [11:0] RUN_IDX     = 12'h100;
    localparam logic [11:0] CMP0_IDX    = 12'h102;
    localparam logic [11:0] CMP1_IDX    = 12'h103;
    localparam logic [11:0] MODE_IDX    = 12'h104;
    localparam logic [11:0] FFCR_IDX    = 12'h105;
    localparam logic [11:0] STATUS_IDX  = 12'h106;
    localparam logic [11:0] CMP2_IDX    = 12'h10a;
    localparam logic [11:0] CMP3_IDX    = 12'h10b;

    // Field positions in the run control register.
    localparam int RUN_FIRST_BIT   = 0;
    localparam int RUN_SECOND_BIT  = 1;
    localparam int RUN_PRESC_BIT   = 2;
    localparam int RUN_BUFEN_BIT   = 7;

    // Field positions in the mode register.
    localparam int MODE_CLK0_LSB   = 0;
    localparam int MODE_CLK1_LSB   = 2;
    localparam int MODE_PWM_LSB    = 4;
    localparam int MODE_OP_LSB     = 6;

    // Field positions in the flip-flop control register.
    localparam int FFCR_SRC_BIT    = 0;
    localparam int FFCR_IE_BIT     = 1;
    localparam int FFCR_CMD_LSB    = 2;

    // Values after reset.
    localparam logic [7:0] RUN_RESET   = 8'h00;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] FFCR_RESET  = 8'h0c;
    localparam logic [7:0] CMP_RESET   = 8'h00;

    // Prescaler width and the bit counts at which each tap fires.
    localparam int PRESC_W    = 9;
    localparam int TAP1_BITS  = 1;
    localparam int TAP4_BITS  = 3;
    localparam int TAP16_BITS = 5;
    localparam int TAP256_BITS = 9;

    // Software commands on the output flip-flop.
    localparam logic [1:0] FF_INVERT = 2'b00;
    localparam logic [1:0] FF_SET    = 2'b01;
    localparam logic [1:0] FF_CLEAR  = 2'b10;

    // Operating modes of the pair.
    typedef enum logic [1:0] {
        MODE_TWO_8BIT = 2'b00,
        MODE_16BIT    = 2'b01,
        MODE_PPG      = 2'b10,
        MODE_PWM      = 2'b11
    } pair_mode_t;

    // One-cycle tap pulses from the prescaler.
    typedef struct packed {
        logic tap256;
        logic tap16;
        logic tap4;
        logic tap1;
    } tap_pulses_t;

endpackage : timer_pair_pkg

// File: hdl/pair_prescaler.sv
// Prescaler producing the tap pulses for the timer pair.
`timescale 1ns/100ps
module pair_prescaler (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      prescaler_run,
    output timer_pair_pkg::tap_pulses_t    taps
);
    import timer_pair_pkg::*;

    logic [PRESC_W-1:0] presc_q;

    // Count while running; stopping clears the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else if (!prescaler_run) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // A tap fires each time its low bits are all ones.
    always_comb begin
        taps.tap1   = prescaler_run && (&presc_q[TAP1_BITS-1:0]);
        taps.tap4   = prescaler_run && (&presc_q[TAP4_BITS-1:0]);
        taps.tap16  = prescaler_run && (&presc_q[TAP16_BITS-1:0]);
        taps.tap256 = prescaler_run && (&presc_q[TAP256_BITS-1:0]);
    end

endmodule : pair_prescaler

// File: hdl/timer_pair_module.sv
// Paired 8-bit interval timers with APB registers and output flip-flop.
`timescale 1ns/100ps
// How it works
// - Each channel has an 8-bit up counter.
// - First clock: pin, tap 1, 4, 16.
// - Second clock: match/taps, or overflow in 16-bit.
// - Run bits start; clearing stops and clears.
// - Match on equality; zero compare matches overflow.
// - Match clears counter and pulses interrupt (first channel: not in PWM/PPG), may toggle.
// - Buffer enable bit, reset to disabled.
// - Buffer copies at PWM wrap or PPG start.
// - Shared address; buffered write loads buffer only.
// - Compare registers are write-only, read zero.
// - Match toggling gated by enable bit.
// - Reset clears the output flip-flop.
// - Software command inverts, sets, clears or holds.
// - Nine-bit prescaler with run bit clearing it.
module timer_pair_module (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_input,
    output logic             timer_output_pin,
    output logic             first_match_interrupt,
    output logic             second_match_interrupt
);
    import timer_pair_pkg::*;

    // Picks one of four pulse sources by a 2-bit select.
    function automatic logic pick_tick(input logic [1:0] sel,
                                       input logic [3:0] src);
        pick_tick = src[sel];
    endfunction : pick_tick

    // Tells whether a byte address names a register, and which.
    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] idx);
        addr_is = (a == {idx[9:0], 2'b00});
    endfunction : addr_is

    logic [7:0]  run_q;
    logic [7:0]  mode_q;
    logic        ff_src_q;
    logic        ff_ie_q;
    logic [7:0]  cmp0_q;
    logic [7:0]  cmp0_buf_q;
    logic [7:0]  cmp1_q;
    logic [7:0]  cnt_q [2];
    logic        ff_q;
    logic        irq0_q;
    logic        irq1_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [2:0]  ext_sync_q;
    tap_pulses_t taps;
    pair_mode_t  mode;
    logic        wr_en;
    logic        setup_rd;
    logic        mapped;
    logic        tick [2];
    logic        clr [2];
    logic        ovf0;
    logic        match0;
    logic        match1;
    logic        pwm_wrap;
    logic        ppg_start;
    logic        toggle_hit;
    logic        ext_edge;
    logic [7:0]  nxt0;
    logic [7:0]  nxt1;

    // Prescaler shared by both channels.
    pair_prescaler u_presc (
        .pclk          (pclk),
        .presetn       (presetn),
        .prescaler_run (run_q[RUN_PRESC_BIT]),
        .taps          (taps)
    );

    // Two flip-flops bring the pin in; the third gives the edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_count_input};
        end
    end
    assign ext_edge = ext_sync_q[1] && !ext_sync_q[2];

    // Bus decode; every access finishes with no wait state.
    assign mode     = pair_mode_t'(mode_q[MODE_OP_LSB +: 2]);
    assign wr_en    = psel && penable && pwrite;
    assign setup_rd = psel && !penable;
    assign pready   = 1'b1;
    assign prdata   = prdata_q;
    assign pslverr  = pslverr_q;
    assign mapped   = addr_is(paddr, RUN_IDX) || addr_is(paddr, CMP0_IDX)
                   || addr_is(paddr, CMP1_IDX) || addr_is(paddr, MODE_IDX)
                   || addr_is(paddr, FFCR_IDX) || addr_is(paddr, STATUS_IDX)
                   || addr_is(paddr, CMP2_IDX) || addr_is(paddr, CMP3_IDX);

    // Read data and error are registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (setup_rd) begin
            pslverr_q <= !mapped;
            if (pwrite) begin
                prdata_q <= 32'h0;
            end else if (addr_is(paddr, RUN_IDX)) begin
                prdata_q <= {24'h0, run_q};
            end else if (addr_is(paddr, MODE_IDX)) begin
                prdata_q <= {24'h0, mode_q};
            end else if (addr_is(paddr, STATUS_IDX)) begin
                prdata_q <= {15'h0, ff_q, cnt_q[1], cnt_q[0]};
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    // Run, mode and flip-flop control bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q    <= RUN_RESET;
            mode_q   <= MODE_RESET;
            ff_src_q <= FFCR_RESET[FFCR_SRC_BIT];
            ff_ie_q  <= FFCR_RESET[FFCR_IE_BIT];
        end else if (wr_en) begin
            if (addr_is(paddr, RUN_IDX)) begin
                run_q <= pwdata[7:0];
            end else if (addr_is(paddr, MODE_IDX)) begin
                mode_q <= pwdata[7:0];
            end else if (addr_is(paddr, FFCR_IDX)) begin
                ff_src_q <= pwdata[FFCR_SRC_BIT];
                ff_ie_q  <= pwdata[FFCR_IE_BIT];
            end
        end
    end

    // Compare registers; the first has a buffer behind one address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp0_q     <= CMP_RESET;
            cmp0_buf_q <= CMP_RESET;
            cmp1_q     <= CMP_RESET;
        end else begin
            if (wr_en && addr_is(paddr, CMP0_IDX)) begin
                cmp0_buf_q <= pwdata[7:0];
                if (!run_q[RUN_BUFEN_BIT]) begin
                    cmp0_q <= pwdata[7:0];
                end
            end else if (run_q[RUN_BUFEN_BIT] && (pwm_wrap || ppg_start))
            begin
                cmp0_q <= cmp0_buf_q;
            end
            if (wr_en && addr_is(paddr, CMP1_IDX)) begin
                cmp1_q <= pwdata[7:0];
            end
        end
    end

    // First channel: clock choice, match, PWM wrap and PPG period.
    always_comb begin
        tick[0]   = run_q[RUN_FIRST_BIT] && pick_tick(
                        mode_q[MODE_CLK0_LSB +: 2],
                        {taps.tap16, taps.tap4, taps.tap1, ext_edge});
        nxt0      = cnt_q[0] + 8'h01;
        ovf0      = tick[0] && (cnt_q[0] == 8'hff);
        match0    = tick[0] && ((cmp0_q == 8'h00) ? (cnt_q[0] == 8'hff)
                                                  : (nxt0 == cmp0_q));
        pwm_wrap  = 1'b0;
        ppg_start = 1'b0;
        if (mode == MODE_PWM) begin
            case (mode_q[MODE_PWM_LSB +: 2])
                2'b01:   pwm_wrap = tick[0] && (&cnt_q[0][5:0]);
                2'b10:   pwm_wrap = tick[0] && (&cnt_q[0][6:0]);
                2'b11:   pwm_wrap = ovf0;
                default: pwm_wrap = 1'b0;
            endcase
        end
        if (mode == MODE_PPG) begin
            ppg_start = tick[0] && (nxt0 == cmp1_q);
        end
        case (mode)
            MODE_PWM: clr[0] = pwm_wrap;
            MODE_PPG: clr[0] = ppg_start;
            default:  clr[0] = match0;
        endcase
    end

    // Second channel: clocked by overflow in 16-bit mode.
    always_comb begin
        if (mode == MODE_16BIT) begin
            tick[1] = run_q[RUN_SECOND_BIT] && ovf0;
        end else begin
            tick[1] = run_q[RUN_SECOND_BIT] && pick_tick(
                          mode_q[MODE_CLK1_LSB +: 2],
                          {taps.tap256, taps.tap16, taps.tap1, match0});
        end
        nxt1   = cnt_q[1] + 8'h01;
        match1 = tick[1] && ((cmp1_q == 8'h00) ? (cnt_q[1] == 8'hff)
                                               : (nxt1 == cmp1_q));
        clr[1] = match1;
    end

    // Both up counters share one structure.
    for (genvar i = 0; i < 2; i++) begin : g_cnt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q[i] <= 8'h00;
            end else if (!run_q[i]) begin
                cnt_q[i] <= 8'h00;
            end else if (tick[i] && clr[i]) begin
                cnt_q[i] <= 8'h00;
            end else if (tick[i]) begin
                cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end
    end

    // Which match toggles the flip-flop in the current mode.
    always_comb begin
        if (mode == MODE_TWO_8BIT) begin
            toggle_hit = ff_src_q ? match1 : match0;
        end else if (mode == MODE_16BIT) begin
            toggle_hit = match1;
        end else begin
            toggle_hit = match0;
        end
    end

    // Output flip-flop: a software command wins over a match toggle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff_q <= 1'b0;
        end else if (wr_en && addr_is(paddr, FFCR_IDX)) begin
            case (pwdata[FFCR_CMD_LSB +: 2])
                FF_INVERT: ff_q <= !ff_q;
                FF_SET:    ff_q <= 1'b1;
                FF_CLEAR:  ff_q <= 1'b0;
                default:   ff_q <= ff_q;
            endcase
        end else if (ff_ie_q && toggle_hit) begin
            ff_q <= !ff_q;
        end
    end

    // Match interrupts are one-cycle registered pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq0_q <= 1'b0;
            irq1_q <= 1'b0;
        end else begin
            irq0_q <= match0 && (mode != MODE_PWM) && (mode != MODE_PPG);
            irq1_q <= match1;
        end
    end

    assign timer_output_pin       = ff_q;
    assign first_match_interrupt  = irq0_q;
    assign second_match_interrupt = irq1_q;

    // Checks on the timer behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stop_clears: assert property (
        !run_q[RUN_FIRST_BIT] |=> cnt_q[0] == 8'h00)
        else $error("stopped first counter not cleared");
    a_match_clears: assert property (
        (match1 && mode != MODE_16BIT) |=> cnt_q[1] == 8'h00
            && second_match_interrupt)
        else $error("second match did not clear or interrupt");
    a_count_step: assert property (
        (tick[0] && !clr[0]) |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01)
        else $error("first counter did not step by one");
    a_zero_cmp: assert property (
        (mode == MODE_TWO_8BIT && cmp1_q == 8'h00 && match1)
            |-> cnt_q[1] == 8'hff)
        else $error("zero compare matched before overflow");
    a_wide_clock: assert property (
        (mode == MODE_16BIT && tick[1]) |-> ovf0)
        else $error("16-bit upper count without overflow");
    a_buf_write: assert property (
        (wr_en && addr_is(paddr, CMP0_IDX) && run_q[RUN_BUFEN_BIT]
            && !pwm_wrap && !ppg_start)
            |=> cmp0_q == $past(cmp0_q))
        else $error("buffered write reached active compare");
    a_toggle_gate: assert property (
        (!ff_ie_q && !(wr_en && addr_is(paddr, FFCR_IDX)))
            |=> $stable(ff_q))
        else $error("flip-flop moved without enable");
    a_sw_set: assert property (
        (wr_en && addr_is(paddr, FFCR_IDX)
            && pwdata[FFCR_CMD_LSB +: 2] == FF_SET) |=> ff_q)
        else $error("set command did not set flip-flop");
    a_wo_read: assert property (
        (setup_rd && !pwrite && addr_is(paddr, CMP0_IDX))
            |=> prdata == 32'h0)
        else $error("compare register read back");
    a_pwm_period: assert property (
        (mode == MODE_PWM && mode_q[MODE_PWM_LSB +: 2] == 2'b01
            && pwm_wrap) |-> cnt_q[0][5:0] == 6'h3f)
        else $error("PWM wrap off period");

    c_first_match: cover property (first_match_interrupt);
    c_toggle: cover property (ff_ie_q && toggle_hit);
    c_buf_copy: cover property (run_q[RUN_BUFEN_BIT] && pwm_wrap);
    c_wide: cover property (mode == MODE_16BIT && tick[1]);

endmodule : timer_pair_module

// File: sim/timer_pair_module_tb_top.sv
// Self-checking testbench for the paired 8-bit interval timer.
`timescale 1ns/100ps
module timer_pair_module_tb_top;
    import timer_pair_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        ext_in;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        out_pin;
    logic        irq0;
    logic        irq1;
    logic        err;
    int          fail_count;
    int          n_tests;
    int          cyc;
    logic [11:0] cmp_idx [4] = '{CMP0_IDX, CMP1_IDX, CMP2_IDX, CMP3_IDX};
    // Channel, clock select, compare value, expected match interval.
    int          tbl [9][4] = '{'{0, 1, 3, 6}, '{0, 2, 3, 24},
                                '{0, 3, 3, 96}, '{0, 1, 0, 512},
                                '{1, 0, 2, 12}, '{1, 1, 3, 6},
                                '{1, 2, 3, 96}, '{1, 3, 1, 512},
                                '{1, 1, 0, 512}};
    // Software command and expected flip-flop level after it.
    logic [1:0]  cmd [4] = '{2'b01, 2'b10, 2'b00, 2'b11};
    logic        cmd_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    timer_pair_module uut (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .external_count_input   (ext_in),
        .timer_output_pin       (out_pin),
        .first_match_interrupt  (irq0),
        .second_match_interrupt (irq1)
    );

    // Free-running 50 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Prints the verdict and stops the run.
    task end_of_test;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Compares a seen value with an expected one.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high, for at most 50 cycles.
    task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx[9:0], 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h000000, d});
    endtask : wr

    // Waits for a match interrupt pulse under a bounded count.
    task wait_irq(input logic ch, output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (((ch ? irq1 : irq0) !== 1'b1) && n < 2000);
    endtask : wait_irq

    // Measures the cycles between two interrupt pulses.
    task meas(input logic ch, output int n);
        wait_irq(ch, n);
        wait_irq(ch, n);
    endtask : meas

    // Main test sequence.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        ext_in = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Values after reset.
        apb(1'b0, RUN_IDX, 0);
        chk(rd, 32'h0);
        apb(1'b0, MODE_IDX, 0);
        chk(rd, 32'h0);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd, 32'h0);
        chk(out_pin, 1'b0);
        // Compare registers accept writes but never read back.
        for (int i = 0; i < 4; i++) begin
            wr(cmp_idx[i], 8'h5a);
            apb(1'b0, cmp_idx[i], 0);
            chk(rd, 32'h0);
        end
        // An unmapped word reads zero and flags an error.
        apb(1'b0, 12'h101, 0);
        chk({rd[30:0], err}, 32'h1);
        // Software commands on the output flip-flop.
        for (int i = 0; i < 4; i++) begin
            wr(FFCR_IDX, {4'h0, cmd[i], 2'b00});
            @(negedge pclk);
            chk(out_pin, cmd_exp[i]);
        end
        // Counter must not advance while the prescaler is stopped.
        wr(MODE_IDX, 8'h01);
        wr(CMP0_IDX, 8'h03);
        wr(RUN_IDX, 8'h01);
        repeat (20) @(posedge pclk);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd[7:0], 8'h00);
        // Match intervals for the tap clock selects of the first channel and every clock select of the second.
        for (int i = 0; i < 9; i++) begin
            wr(RUN_IDX, 8'h00);
            wr(MODE_IDX, tbl[i][0] ? 8'((tbl[i][1] << 2) | 1) : 8'(tbl[i][1]));
            wr(CMP0_IDX, tbl[i][0] ? 8'h03 : 8'(tbl[i][2]));
            wr(CMP1_IDX, tbl[i][0] ? 8'(tbl[i][2]) : 8'h01);
            wr(RUN_IDX, 8'h07);
            meas(tbl[i][0] != 0, cyc);
            chk(cyc, tbl[i][3]);
        end
        // Clearing the run bits stops and clears both counters.
        wr(RUN_IDX, 8'h04);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd[15:0], 16'h0000);
        // Match toggling, its enable and its source select.
        wr(FFCR_IDX, 8'h08);
        wr(MODE_IDX, 8'h01);
        wr(CMP0_IDX, 8'h03);
        wr(FFCR_IDX, 8'h0e);
        wr(RUN_IDX, 8'h05);
        wait_irq(1'b0, cyc);
        chk(out_pin, 1'b1);
        wait_irq(1'b0, cyc);
        chk(cyc, 6);
        chk(out_pin, 1'b0);
        wr(FFCR_IDX, 8'h0f);
        wait_irq(1'b0, cyc);
        chk(out_pin, 1'b0);
        wr(FFCR_IDX, 8'h0c);
        wait_irq(1'b0, cyc);
        chk(out_pin, 1'b0);
        // Buffered writes reach only the buffer in plain timer mode.
        wr(RUN_IDX, 8'h00);
        wr(CMP0_IDX, 8'h03);
        wr(RUN_IDX, 8'h85);
        apb(1'b0, RUN_IDX, 0);
        chk(rd, 32'h85);
        wr(CMP0_IDX, 8'h05);
        meas(1'b0, cyc);
        chk(cyc, 6);
        wr(RUN_IDX, 8'h05);
        wr(CMP0_IDX, 8'h05);
        meas(1'b0, cyc);
        chk(cyc, 10);
        // Sixteen-bit mode: the upper counter counts lower overflows.
        wr(RUN_IDX, 8'h00);
        wr(MODE_IDX, 8'h45);
        wr(CMP0_IDX, 8'h00);
        wr(CMP1_IDX, 8'h02);
        wr(RUN_IDX, 8'h07);
        meas(1'b1, cyc);
        chk(cyc, 1024);
        // PPG mode: the second compare sets the first channel's period.
        wr(RUN_IDX, 8'h00);
        wr(MODE_IDX, 8'h81);
        wr(CMP0_IDX, 8'h02);
        wr(CMP1_IDX, 8'h04);
        wr(RUN_IDX, 8'h07);
        meas(1'b1, cyc);
        chk(cyc, 32);
        // PWM mode wraps every 64 ticks and copies the buffer there.
        wr(RUN_IDX, 8'h00);
        wr(MODE_IDX, 8'hd1);
        wr(CMP0_IDX, 8'h10);
        wr(CMP1_IDX, 8'h01);
        wr(RUN_IDX, 8'h87);
        meas(1'b1, cyc);
        chk(cyc, 128);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd[7:0], 8'h10);
        wr(CMP0_IDX, 8'h20);
        wait_irq(1'b1, cyc);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd[7:0], 8'h20);
        // External pin edges clock the first counter.
        wr(RUN_IDX, 8'h00);
        wr(MODE_IDX, 8'h00);
        wr(CMP0_IDX, 8'h00);
        wr(RUN_IDX, 8'h05);
        repeat (5) begin
            @(posedge pclk) ext_in <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        apb(1'b0, STATUS_IDX, 0);
        chk(rd[7:0], 8'h05);
        end_of_test();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end
endmodule : timer_pair_module_tb_top
